//--- core/tfee_consts.svh
`ifndef TFEE_CONSTS_SVH
`define TFEE_CONSTS_SVH
// timing
`define TFEE_MCLK_MHZ    125
`define TFEE_PULSE_US    50
`define TFEE_STARTUP_MS  2
// register addresses
`define TFEE_A_ES1   7'h16
`define TFEE_A_ES2   7'h17
`define TFEE_A_STAT  7'h19
`define TFEE_A_REL   7'h1A
`define TFEE_A_MAIN  7'h1B
`define TFEE_A_RATE  7'h1D
`define TFEE_A_PCFG  7'h22
`define TFEE_A_MASK  7'h24
`define TFEE_A_ROUTE 7'h25
`define TFEE_A_TRC   7'h2A
`define TFEE_A_SEP   7'h2B
`define TFEE_A_JHI   7'h2C
`define TFEE_A_JLO   7'h2D
`define TFEE_A_DUR   7'h2E
`define TFEE_A_DDUR  7'h2F
`define TFEE_A_LAT   7'h30
`define TFEE_A_WIN   7'h31
`define TFEE_A_FREEFALL_THRESHOLD  7'h32
`define TFEE_A_FFDB  7'h33
`define TFEE_A_FFC   7'h34
// reset values
`define TFEE_R_ZERO  8'h00
`define TFEE_R_RATE  8'hA8
`define TFEE_R_MASK  8'h3F
`define TFEE_R_TRC   8'h03
`define TFEE_R_SEP   8'h78
`define TFEE_R_JHI   8'h33
`define TFEE_R_JLO   8'h07
`define TFEE_R_DUR   8'hA2
`define TFEE_R_DDUR  8'h24
`define TFEE_R_LAT   8'h28
`define TFEE_R_WIN   8'hA0
// bit positions
`define TFEE_B_OPER   7
`define TFEE_B_TAPEN  2
`define TFEE_B_PULSE  3
`define TFEE_B_POL    4
`define TFEE_B_GATE   5
`define TFEE_B_RT_TAP 2
`define TFEE_B_RT_FF  7
`define TFEE_B_FF_EN  7
`define TFEE_B_FF_RST 3
`define TFEE_B_TRC_S  0
`define TFEE_B_TRC_D  1
`define TFEE_B_ANY    4
`define TFEE_B_ES2_FF 7
`define TFEE_B_ES2_DT 3
`define TFEE_B_ES2_ST 2
`define TFEE_SPI_LAST 3'h7
`endif

//--- core/tfee_pkg.sv
package tfee_pkg;
   typedef enum logic [1:0] {
      TAP_IDLE,
      TAP_FIRST,
      TAP_GAP,
      TAP_SECOND
   } tfee_tap_state_t;
endpackage

//--- core/tfee_core.sv
// Behaviour
// - six-bit direction mask, default all enabled
// - report control selects single/double taps
// - double tap needs second end past separation
// - jerk between low and doubled high threshold
// - tap length within min and max counts
// - double-tap total above-time limited
// - latency bounds samples of one tap
// - single tap reported at window end
// - tap sets global, type and direction flags
// - routing bits send events to pin one
// - release read deasserts latched pin
// - free-fall control: enable and debounce counter reset mode
// - free fall when all axes below threshold
// - debounce counts free-fall rate periods
// - free fall sets flags and pin
// - outputs valid after start-up time
// - latched level or about 50 us pulse
// - pin polarity select
// - gate bit must be set for events to reach pin
// - release read clears status flags
// - tap counters advance per tap sample
`timescale 1ns/1ns
`default_nettype none
`include "tfee_consts.svh"
module tfee_core
   import tfee_pkg::*;
#(
   parameter int unsigned PULSE_CYC   = `TFEE_PULSE_US * `TFEE_MCLK_MHZ,
   parameter int unsigned STARTUP_CYC = `TFEE_STARTUP_MS * 1000 * `TFEE_MCLK_MHZ
) (
   // clock, reset, enable
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   // serial register port pins
   input  wire logic       spi_sck,
   input  wire logic       spi_cs_n,
   input  wire logic       spi_mosi,
   output var  logic       spi_miso,
   output var  logic       spi_miso_oe_n,
   // sensing front end
   input  wire logic       tap_tick,
   input  wire logic       ff_tick,
   input  wire logic [8:0] jerk_index,
   input  wire logic [5:0] tap_dir,
   input  wire logic [7:0] mag_x,
   input  wire logic [7:0] mag_y,
   input  wire logic [7:0] mag_z,
   // event and status outputs
   output var  logic       event_pin_one,
   output var  logic       output_valid
);
   localparam int SUW = $clog2(STARTUP_CYC + 1);
   localparam int PW  = $clog2(PULSE_CYC + 1);

   if (PULSE_CYC < 1 || STARTUP_CYC < 1) begin : g_chk
      $error("pulse and start-up counts must be at least one");
   end

   function automatic logic [7:0] inc8(input logic [7:0] v);
      return (v == 8'hFF) ? v : v + 8'h01;
   endfunction

   // registers
   logic [7:0] main_control;
   logic [7:0] engine_rate_control;
   logic [7:0] pin_config;
   logic [7:0] tap_direction_mask;
   logic [7:0] pin_one_routing;
   logic [7:0] tap_report_control;
   logic [7:0] double_tap_separation;
   logic [7:0] jerk_high_threshold;
   logic [7:0] jerk_low_threshold;
   logic [7:0] tap_duration_limits;
   logic [7:0] double_tap_duration;
   logic [7:0] tap_latency;
   logic [7:0] tap_window;
   logic [7:0] freefall_threshold;
   logic [7:0] freefall_debounce;
   logic [7:0] freefall_control;
   // status
   logic [5:0] event_status_one;
   logic       single_tap_flag;
   logic       double_tap_flag;
   logic       ff_flag;
   logic       any_flag;

   // serial port synchronisers and shifter
   logic       sck_s1;
   logic       sck_s2;
   logic       sck_s3;
   logic       cs_s1;
   logic       cs_s2;
   logic       mosi_s1;
   logic       mosi_s2;
   logic [2:0] bitc;
   logic [6:0] shreg;
   logic       have_addr;
   logic       rw;
   logic [6:0] addr;
   logic [7:0] tx;

   wire        sel       = ~cs_s2;
   wire        rise      = sel & sck_s2 & ~sck_s3;
   wire        fall      = sel & ~sck_s2 & sck_s3;
   wire [7:0]  byte_in   = {shreg, mosi_s2};
   wire        byte_done = ce & rise & (bitc == `TFEE_SPI_LAST);
   wire [6:0]  rd_addr   = have_addr ? addr + 7'h01 : byte_in[6:0];
   wire        rd_mode   = have_addr ? rw : byte_in[7];
   wire        wr_en     = byte_done & have_addr & ~rw;
   // address byte only: a burst prefetch into the release slot must not clear
   wire        rel_rd    = byte_done & ~have_addr & byte_in[7]
                         & (byte_in[6:0] == `TFEE_A_REL);
   logic [7:0] rdata;

   always_comb begin
      unique case (rd_addr)
         `TFEE_A_ES1:   rdata = {2'b00, event_status_one};
         `TFEE_A_ES2:   rdata = {ff_flag, 3'b000, double_tap_flag,
                                 single_tap_flag, 2'b00};
         `TFEE_A_STAT:  rdata = {3'b000, any_flag, 4'b0000};
         `TFEE_A_MAIN:  rdata = main_control;
         `TFEE_A_RATE:  rdata = engine_rate_control;
         `TFEE_A_PCFG:  rdata = pin_config;
         `TFEE_A_MASK:  rdata = tap_direction_mask;
         `TFEE_A_ROUTE: rdata = pin_one_routing;
         `TFEE_A_TRC:   rdata = tap_report_control;
         `TFEE_A_SEP:   rdata = double_tap_separation;
         `TFEE_A_JHI:   rdata = jerk_high_threshold;
         `TFEE_A_JLO:   rdata = jerk_low_threshold;
         `TFEE_A_DUR:   rdata = tap_duration_limits;
         `TFEE_A_DDUR:  rdata = double_tap_duration;
         `TFEE_A_LAT:   rdata = tap_latency;
         `TFEE_A_WIN:   rdata = tap_window;
         `TFEE_A_FREEFALL_THRESHOLD:  rdata = freefall_threshold;
         `TFEE_A_FFDB:  rdata = freefall_debounce;
         `TFEE_A_FFC:   rdata = freefall_control;
         default:       rdata = `TFEE_R_ZERO;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         {sck_s1, sck_s2, sck_s3} <= 3'h0;
         {cs_s1, cs_s2}           <= 2'h3;
         {mosi_s1, mosi_s2}       <= 2'h0;
      end else if (ce) begin
         sck_s1  <= spi_sck;
         sck_s2  <= sck_s1;
         sck_s3  <= sck_s2;
         cs_s1   <= spi_cs_n;
         cs_s2   <= cs_s1;
         mosi_s1 <= spi_mosi;
         mosi_s2 <= mosi_s1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bitc          <= 3'h0;
         shreg         <= 7'h00;
         have_addr     <= 1'b0;
         rw            <= 1'b0;
         addr          <= 7'h00;
         tx            <= 8'h00;
         spi_miso      <= 1'b0;
         spi_miso_oe_n <= 1'b1;
      end else if (ce) begin
         spi_miso_oe_n <= ~sel;
         if (!sel) begin
            bitc      <= 3'h0;
            have_addr <= 1'b0;
         end else if (rise) begin
            bitc  <= bitc + 3'h1;
            shreg <= byte_in[6:0];
            if (bitc == `TFEE_SPI_LAST) begin
               have_addr <= 1'b1;
               rw        <= rd_mode;
               addr      <= have_addr ? addr + 7'h01 : byte_in[6:0];
               tx        <= rdata;
            end
         end else if (fall) begin
            spi_miso <= tx[7];
            tx       <= {tx[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         main_control          <= `TFEE_R_ZERO;
         engine_rate_control   <= `TFEE_R_RATE;
         pin_config            <= `TFEE_R_ZERO;
         tap_direction_mask    <= `TFEE_R_MASK;
         pin_one_routing       <= `TFEE_R_ZERO;
         tap_report_control    <= `TFEE_R_TRC;
         double_tap_separation <= `TFEE_R_SEP;
         jerk_high_threshold   <= `TFEE_R_JHI;
         jerk_low_threshold    <= `TFEE_R_JLO;
         tap_duration_limits   <= `TFEE_R_DUR;
         double_tap_duration   <= `TFEE_R_DDUR;
         tap_latency           <= `TFEE_R_LAT;
         tap_window            <= `TFEE_R_WIN;
         freefall_threshold    <= `TFEE_R_ZERO;
         freefall_debounce     <= `TFEE_R_ZERO;
         freefall_control      <= `TFEE_R_ZERO;
      end else if (wr_en) begin
         unique case (addr)
            `TFEE_A_MAIN:  main_control          <= byte_in;
            `TFEE_A_RATE:  engine_rate_control   <= byte_in;
            `TFEE_A_PCFG:  pin_config            <= byte_in;
            `TFEE_A_MASK:  tap_direction_mask    <= byte_in;
            `TFEE_A_ROUTE: pin_one_routing       <= byte_in;
            `TFEE_A_TRC:   tap_report_control    <= byte_in;
            `TFEE_A_SEP:   double_tap_separation <= byte_in;
            `TFEE_A_JHI:   jerk_high_threshold   <= byte_in;
            `TFEE_A_JLO:   jerk_low_threshold    <= byte_in;
            `TFEE_A_DUR:   tap_duration_limits   <= byte_in;
            `TFEE_A_DDUR:  double_tap_duration   <= byte_in;
            `TFEE_A_LAT:   tap_latency           <= byte_in;
            `TFEE_A_WIN:   tap_window            <= byte_in;
            `TFEE_A_FREEFALL_THRESHOLD:  freefall_threshold    <= byte_in;
            `TFEE_A_FFDB:  freefall_debounce     <= byte_in;
            `TFEE_A_FFC:   freefall_control      <= byte_in;
            default: ;
         endcase
      end
   end

   // tap engine
   tfee_tap_state_t tap_state;
   tfee_tap_state_t next_tap_state;
   logic [7:0] win;
   logic [7:0] run;
   logic [7:0] tot;
   logic [5:0] dir;
   logic [7:0] next_win;
   logic [7:0] next_run;
   logic [7:0] next_tot;
   logic [5:0] next_dir;
   logic       tap_single;
   logic       tap_double;

   wire operating = main_control[`TFEE_B_OPER];
   wire tap_run   = operating & main_control[`TFEE_B_TAPEN];
   wire tap_step  = tap_tick & ce;
   wire above     = (jerk_index > {1'b0, jerk_low_threshold})
                  & (jerk_index < {jerk_high_threshold, 1'b0});
   wire run_ok    = (run >= {5'h00, tap_duration_limits[2:0]})
                  & (run <= {3'h0, tap_duration_limits[7:3]});
   wire dir_ok    = |(dir & tap_direction_mask[5:0]);
   wire rep_single = tap_single & dir_ok & tap_report_control[`TFEE_B_TRC_S];
   wire rep_double = tap_double & dir_ok & tap_report_control[`TFEE_B_TRC_D];

   always_comb begin
      next_tap_state = tap_state;
      next_win       = win;
      next_run       = run;
      next_tot       = tot;
      next_dir       = dir;
      tap_single     = 1'b0;
      tap_double     = 1'b0;
      if (!tap_run) begin
         next_tap_state = TAP_IDLE;
         next_win       = 8'h00;
         next_run       = 8'h00;
         next_tot       = 8'h00;
      end else if (tap_step) begin
         next_win = inc8(win);
         unique case (tap_state)
            TAP_IDLE: begin
               if (above) begin
                  next_tap_state = TAP_FIRST;
                  next_win       = 8'h01;
                  next_run       = 8'h01;
                  next_tot       = 8'h01;
                  next_dir       = tap_dir;
               end
            end
            TAP_FIRST: begin
               if (above && run >= tap_latency) begin
                  next_tap_state = TAP_IDLE;
               end else if (above) begin
                  next_run = inc8(run);
                  next_tot = inc8(tot);
               end else begin
                  next_tap_state = run_ok ? TAP_GAP : TAP_IDLE;
               end
            end
            TAP_GAP: begin
               if (win >= tap_window) begin
                  tap_single     = 1'b1;
                  next_tap_state = TAP_IDLE;
               end else if (above) begin
                  next_tap_state = TAP_SECOND;
                  next_run       = 8'h01;
                  next_tot       = inc8(tot);
               end
            end
            TAP_SECOND: begin
               if (win >= tap_window) begin
                  tap_single     = 1'b1;
                  next_tap_state = TAP_IDLE;
               end else if (above && run < tap_latency) begin
                  next_run = inc8(run);
                  next_tot = inc8(tot);
               end else if (above) begin
                  next_tap_state = TAP_GAP;
               end else if (run_ok && win > double_tap_separation
                            && tot <= double_tap_duration) begin
                  tap_double     = 1'b1;
                  next_tap_state = TAP_IDLE;
               end else begin
                  next_tap_state = TAP_GAP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tap_state <= TAP_IDLE;
         win       <= 8'h00;
         run       <= 8'h00;
         tot       <= 8'h00;
         dir       <= 6'h00;
      end else if (ce) begin
         tap_state <= next_tap_state;
         win       <= next_win;
         run       <= next_run;
         tot       <= next_tot;
         dir       <= next_dir;
      end
   end

   // free-fall engine
   logic [7:0] ffcnt;
   logic [7:0] next_ffcnt;
   wire ff_run  = operating & freefall_control[`TFEE_B_FF_EN];
   wire below   = (mag_x < freefall_threshold) & (mag_y < freefall_threshold)
                & (mag_z < freefall_threshold);
   wire ff_hit  = ff_run & ff_tick & ce & below
                & (inc8(ffcnt) >= freefall_debounce)
                & (ffcnt < freefall_debounce);

   always_comb begin
      next_ffcnt = ffcnt;
      if (!ff_run) begin
         next_ffcnt = 8'h00;
      end else if (ff_tick) begin
         if (below) begin
            next_ffcnt = inc8(ffcnt);
         end else if (freefall_control[`TFEE_B_FF_RST]) begin
            next_ffcnt = 8'h00;
         end else if (ffcnt != 8'h00) begin
            next_ffcnt = ffcnt - 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ffcnt <= 8'h00;
      end else if (ce) begin
         ffcnt <= next_ffcnt;
      end
   end

   // status flags, set wins over release
   wire tap_evt = rep_single | rep_double;
   wire clr     = rel_rd;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         single_tap_flag  <= 1'b0;
         double_tap_flag  <= 1'b0;
         ff_flag          <= 1'b0;
         any_flag         <= 1'b0;
         event_status_one <= 6'h00;
      end else if (ce) begin
         single_tap_flag  <= rep_single | (single_tap_flag & ~clr);
         double_tap_flag  <= rep_double | (double_tap_flag & ~clr);
         ff_flag          <= ff_hit | (ff_flag & ~clr);
         any_flag         <= tap_evt | ff_hit | (any_flag & ~clr);
         if (tap_evt) begin
            event_status_one <= dir & tap_direction_mask[5:0];
         end else if (clr) begin
            event_status_one <= 6'h00;
         end
      end
   end

   // event pin
   logic          pend;
   logic [PW-1:0] pcnt;
   wire routed   = (tap_evt & pin_one_routing[`TFEE_B_RT_TAP])
                 | (ff_hit & pin_one_routing[`TFEE_B_RT_FF]);
   wire pulse_on = pin_config[`TFEE_B_PULSE];
   wire pol_high = pin_config[`TFEE_B_POL];
   wire act      = pulse_on ? (pcnt != '0) : pend;
   wire gated    = act & pin_config[`TFEE_B_GATE];
   wire next_pin = pol_high ? gated : ~gated;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pend          <= 1'b0;
         pcnt          <= '0;
         event_pin_one <= 1'b1;
      end else if (ce) begin
         pend          <= routed | (pend & ~rel_rd);
         event_pin_one <= next_pin;
         if (routed) begin
            pcnt <= PW'(PULSE_CYC);
         end else if (pcnt != '0) begin
            pcnt <= pcnt - PW'(1);
         end
      end
   end

   // start-up timer
   logic [SUW-1:0] su_cnt;
   wire su_done = (su_cnt == SUW'(STARTUP_CYC));

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         su_cnt       <= '0;
         output_valid <= 1'b0;
      end else if (ce) begin
         if (!operating) begin
            su_cnt <= '0;
         end else if (!su_done) begin
            su_cnt <= su_cnt + SUW'(1);
         end
         output_valid <= operating & su_done;
      end
   end

   // checks
   property p_mask_gate;
      @(posedge mclk) disable iff (!rst_n)
         tap_evt |-> (dir & tap_direction_mask[5:0]) != 6'h00;
   endproperty
   a_mask_gate: assert property (p_mask_gate) else $error("tap from masked direction");

   property p_report_sel;
      @(posedge mclk) disable iff (!rst_n)
         rep_double |-> tap_report_control[`TFEE_B_TRC_D] && tap_state == TAP_SECOND;
   endproperty
   a_report_sel: assert property (p_report_sel) else $error("double tap not enabled");

   property p_separation;
      @(posedge mclk) disable iff (!rst_n)
         tap_double |-> win > double_tap_separation && tot <= double_tap_duration;
   endproperty
   a_separation: assert property (p_separation) else $error("double tap too close");

   property p_jerk_high;
      @(posedge mclk) disable iff (!rst_n)
         (tap_state == TAP_IDLE && tap_step && jerk_index >= {jerk_high_threshold, 1'b0})
         |=> tap_state == TAP_IDLE;
   endproperty
   a_jerk_high: assert property (p_jerk_high) else $error("tap above high threshold");

   property p_short_tap;
      @(posedge mclk) disable iff (!rst_n)
         (tap_run && tap_step && tap_state == TAP_FIRST && !above
          && run < {5'h00, tap_duration_limits[2:0]}) |=> tap_state == TAP_IDLE;
   endproperty
   a_short_tap: assert property (p_short_tap) else $error("short tap accepted");

   property p_tap_flags;
      @(posedge mclk) disable iff (!rst_n)
         (ce && rep_double) |=> (double_tap_flag && any_flag)
         ##1 (double_tap_flag || $past(clr));
   endproperty
   a_tap_flags: assert property (p_tap_flags) else $error("double tap flag missing");

   property p_ff_flags;
      @(posedge mclk) disable iff (!rst_n)
         ff_hit |=> ff_flag && any_flag;
   endproperty
   a_ff_flags: assert property (p_ff_flags) else $error("free-fall flag missing");

   property p_release;
      @(posedge mclk) disable iff (!rst_n)
         (rel_rd && !routed && !pulse_on && ce) |=> !pend ##1
         (!pin_config[`TFEE_B_GATE] || event_pin_one == !pol_high || !ce || routed
          || pulse_on || $changed(pin_config));
   endproperty
   a_release: assert property (p_release) else $error("pin not released");

   property p_gate;
      @(posedge mclk) disable iff (!rst_n)
         (ce && !pin_config[`TFEE_B_GATE]) |=> event_pin_one == !$past(pol_high);
   endproperty
   a_gate: assert property (p_gate) else $error("gated pin not idle");

   property p_standby;
      @(posedge mclk) disable iff (!rst_n)
         (ce && !operating) |=> tap_state == TAP_IDLE && ffcnt == 8'h00;
   endproperty
   a_standby: assert property (p_standby) else $error("engine active in standby");

   c_single: cover property (@(posedge mclk) disable iff (!rst_n) rep_single);
   c_double: cover property (@(posedge mclk) disable iff (!rst_n) rep_double);
   c_ff:     cover property (@(posedge mclk) disable iff (!rst_n) ff_hit);
   c_rel:    cover property (@(posedge mclk) disable iff (!rst_n) pend && rel_rd);
endmodule
`default_nettype wire

//--- verif/tfee_host.sv
`timescale 1ns/1ns
`default_nettype none
module tfee_host (
   // serial pins
   output var  logic spi_sck,
   output var  logic spi_cs_n,
   output var  logic spi_mosi,
   input  wire logic spi_miso
);
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end
   // one register per frame, mode 0, msb first, 80 ns bit period
   task automatic xfer(input logic rdn, input logic [6:0] a, input logic [7:0] wd,
                       output logic [7:0] rdat);
      logic [15:0] sh;
      sh = {rdn, a, wd};
      spi_cs_n = 1'b0;
      #80;
      for (int i = 15; i >= 0; i--) begin
         spi_mosi = sh[i];
         #40 spi_sck = 1'b1;
         if (i < 8)
            rdat[i] = spi_miso;
         #40 spi_sck = 1'b0;
      end
      #80 spi_cs_n = 1'b1;
      // released line shows no stale level
      spi_mosi = ~spi_mosi;
      #160;
   endtask
endmodule
`default_nettype wire

//--- verif/test_tap_freefall_event_engine.sv
`timescale 1ns/1ns
`default_nettype none
`include "tfee_consts.svh"
module test_tap_freefall_event_engine;
   logic       mclk;
   logic       rst_n;
   logic       tap_tick;
   logic       ff_tick;
   logic [8:0] jerk;
   logic [5:0] dir;
   logic [7:0] mag [3];
   logic [7:0] rd;
   logic [7:0] model [128];
   logic [6:0] ra [10] = '{7'h1D, 7'h24, 7'h2A, 7'h2B, 7'h2C, 7'h2D, 7'h2E, 7'h2F, 7'h30, 7'h31};
   logic [7:0] rv [10] = '{8'hA8, 8'h3F, 8'h03, 8'h78, 8'h33, 8'h07, 8'hA2, 8'h24, 8'h28, 8'hA0};
   logic [7:0] cfgs [4] = '{8'h30, 8'h20, 8'h38, 8'h10};
   int         n_errors;
   int         checks;
   wire        sck;
   wire        cs_n;
   wire        mosi;
   wire        miso;
   wire        pin;
   wire        ovalid;
   wire        miso_oe_n;

   tfee_core #(.PULSE_CYC(8), .STARTUP_CYC(16)) uut (
      .mclk(mclk), .rst_n(rst_n), .ce(1'b1), .spi_sck(sck), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe_n(miso_oe_n), .tap_tick(tap_tick),
      .ff_tick(ff_tick), .jerk_index(jerk), .tap_dir(dir), .mag_x(mag[0]),
      .mag_y(mag[1]), .mag_z(mag[2]), .event_pin_one(pin), .output_valid(ovalid));
   tfee_host host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));

   always #4 mclk = ~mclk;

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.xfer(1'b0, a, d, rd);
      if (a == 7'h1B || a == 7'h1D || a == 7'h22 || a == 7'h24 || a == 7'h25
          || (a >= 7'h2A && a <= 7'h34))
         model[a] = d;
   endtask
   task automatic rdchk(input logic [6:0] a);
      host.xfer(1'b1, a, 8'h00, rd);
      if (a == `TFEE_A_REL) begin
         model[`TFEE_A_ES1] = 8'h00;
         model[`TFEE_A_ES2] = 8'h00;
         model[`TFEE_A_STAT] = 8'h00;
      end else
         check($sformatf("reg %h", a), model[a], rd);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic tick(input logic ff);
      ff_tick = ff;
      tap_tick = ~ff;
      @(posedge mclk) #1 ff_tick = 1'b0;
      tap_tick = 1'b0;
      wait_cyc(3);
   endtask
   task automatic ff_run(input logic [7:0] cfg);
      wr(`TFEE_A_MAIN, 8'h00);
      check("valid off", 8'h00, {7'h00, ovalid});
      wr(`TFEE_A_PCFG, cfg);
      wr(`TFEE_A_MAIN, 8'h80);
      check("valid on", 8'h01, {7'h00, ovalid});
      wait_cyc(4);
      foreach (mag[i]) mag[i] = 8'($urandom_range(7));
      repeat (3) tick(1'b1);
      check("pin early", {7'h00, ~cfg[4]}, {7'h00, pin});
      tick(1'b1);
      check("pin", {7'h00, cfg[5] ? cfg[4] : ~cfg[4]}, {7'h00, pin});
      wait_cyc(20);
      check("pin hold", {7'h00, cfg[5] && !cfg[3] ? cfg[4] : ~cfg[4]}, {7'h00, pin});
      model[`TFEE_A_ES2] = 8'h80;
      model[`TFEE_A_STAT] = 8'h10;
      rdchk(`TFEE_A_ES2);
      rdchk(`TFEE_A_STAT);
      rdchk(`TFEE_A_REL);
      wait_cyc(3);
      check("pin released", {7'h00, ~cfg[4]}, {7'h00, pin});
      rdchk(`TFEE_A_STAT);
   endtask
   task automatic report_and_stop;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      #640000;
      n_errors++;
      report_and_stop();
   end

   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      tap_tick = 1'b0;
      ff_tick = 1'b0;
      jerk = 9'h000;
      dir = 6'h00;
      mag = '{8'hFF, 8'hFF, 8'hFF};
      n_errors = 0;
      checks = 0;
      for (int i = 0; i < 128; i++) model[i] = 8'h00;
      foreach (ra[i]) model[ra[i]] = rv[i];
      void'($urandom(32'h5CA186B3));
      repeat (8) @(posedge mclk);
      #1 rst_n = 1'b1;
      check("valid reset", 8'h00, {7'h00, ovalid});
      check("pin idle", 8'h01, {7'h00, pin});
      check("miso oe idle", 8'h01, {7'h00, miso_oe_n});
      wait_cyc(2);
      for (int a = 16; a < 64; a++) begin
         rdchk(7'(a));
         wr(7'(a), 8'($urandom));
         rdchk(7'(a));
      end
      wr(`TFEE_A_MAIN, 8'h00);
      foreach (ra[i]) wr(ra[i], rv[i]);
      wr(`TFEE_A_FREEFALL_THRESHOLD, 8'h08);
      wr(`TFEE_A_FFDB, 8'h04);
      wr(`TFEE_A_FFC, 8'h80);
      wr(`TFEE_A_ROUTE, 8'h80);
      foreach (cfgs[i]) ff_run(cfgs[i]);
      wr(`TFEE_A_MAIN, 8'h00);
      wr(`TFEE_A_WIN, 8'h0C);
      wr(`TFEE_A_PCFG, 8'h30);
      wr(`TFEE_A_ROUTE, 8'h04);
      wr(`TFEE_A_MAIN, 8'h84);
      wait_cyc(4);
      dir = 6'(1 << $urandom_range(5));
      jerk = 9'($urandom_range(101, 8));
      repeat (4) tick(1'b0);
      jerk = 9'h000;
      repeat (2) tick(1'b0);
      check("pin window", 8'h00, {7'h00, pin});
      repeat (20) tick(1'b0);
      check("pin tap", 8'h01, {7'h00, pin});
      model[`TFEE_A_ES1] = {2'b00, dir};
      model[`TFEE_A_ES2] = 8'h04;
      model[`TFEE_A_STAT] = 8'h10;
      rdchk(`TFEE_A_ES1);
      rdchk(`TFEE_A_ES2);
      rdchk(`TFEE_A_STAT);
      report_and_stop();
   end
endmodule
`default_nettype wire
